// ### design/asr_readout.sv
/*
 * Read-side register bank for three-axis samples: status byte at 0x00,
 * six data bytes at 0x01..0x06 with auto-increment, fast-read skipping.
 * Status flags clear on high-byte reads. A low byte is served only
 * straight after its high byte, from a copy taken at that high read.
 * With the FIFO on, address 0x00 shows the FIFO status byte, 0x01 shows
 * the byte at the FIFO read pointer, and 0x02..0x06 read as zero.
 * Assumes a serial register front end that presents a one-cycle read
 * strobe with an address, takes the returned byte one cycle later, and
 * uses next_addr as the address of its next sequential read.
 * Assumes the FIFO block supplies its status and head byte as levels
 * and advances its read pointer on fifo_pop.
 * Assumes all inputs are synchronous to clk, and that new_sample bits
 * are one-cycle strobes with the sample words valid in that cycle.
 */
`timescale 1ns/10ps
`default_nettype none
`include "asr_params.svh"
//////////////////////////////////////////////////////////////////////////
module asr_readout
   import asr_pkg::*;
#(
   parameter int SAMPLE_W = `ASR_SAMPLE_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] fifo_mode,
   input wire logic fast_read,
   input wire logic [7:0] fifo_status,
   input wire logic [7:0] fifo_data,
   output logic fifo_pop,
   input wire logic [2:0] new_sample,
   input wire logic [SAMPLE_W-1:0] x_sample_in,
   input wire logic [SAMPLE_W-1:0] y_sample_in,
   input wire logic [SAMPLE_W-1:0] z_sample_in,
   input wire logic read_strobe,
   input wire logic [7:0] read_addr,
   output logic [7:0] read_data,
   output logic [7:0] next_addr
);
   // The byte split is fixed at an 8-bit high byte and a 4-bit low
   // nibble, so only a 12-bit sample can be served.
   if (SAMPLE_W != `ASR_SAMPLE_W) begin : g_width_check
      $error("asr_readout supports 12-bit samples only");
   end
   // Auto-increment wraps after the Z low byte.
   if (`ASR_ADDR_LAST != `ASR_ADDR_Z_LOW) begin : g_map_check
      $error("asr_readout data block must end at the Z low byte");
   end

   // State of the bank: the registered read byte, the high bytes of the
   // current sample set that are still unread, the combined flags, and
   // the low byte that the next strobe may serve.
   typedef struct packed {
      logic [7:0] read_data;
      logic [2:0] highs_pending;
      logic any_overwrite;
      logic any_ready;
      logic [2:0] low_open;
   } asr_top_s;

   asr_top_s state;
   asr_top_s next_state;
   logic [2:0] read_high;
   logic [7:0] high_byte [3];
   logic [7:0] low_hold [3];
   logic [2:0] ready;
   logic [2:0] overwrite;
   logic fifo_on;
   logic [7:0] status_byte;

   // Maps an address to the next one, with optional low-byte skipping.
   function automatic logic [7:0] step_addr(input logic [7:0] addr, input logic skip);
      logic [7:0] nxt;
      nxt = addr + 8'h01;
      if (addr >= `ASR_ADDR_LAST) begin
         nxt = `ASR_ADDR_STATUS;
      end else if (skip && addr != `ASR_ADDR_STATUS) begin
         nxt = addr + 8'h02;
      end
      if (nxt > `ASR_ADDR_LAST) begin
         nxt = `ASR_ADDR_STATUS;
      end
      return nxt;
   endfunction

   // True for the three high-byte addresses of the data block.
   function automatic logic is_high_addr(input logic [7:0] addr);
      return (addr == `ASR_ADDR_X_HIGH) || (addr == `ASR_ADDR_Y_HIGH) ||
             (addr == `ASR_ADDR_Z_HIGH);
   endfunction

   // Axis that owns a data address; the high and low byte of an axis share it.
   function automatic asr_axis_e axis_of(input logic [7:0] addr);
      asr_axis_e axis;
      axis = ASR_AXIS_X;
      case (addr)
         `ASR_ADDR_Y_HIGH, `ASR_ADDR_Y_LOW: begin
            axis = ASR_AXIS_Y;
         end
         `ASR_ADDR_Z_HIGH, `ASR_ADDR_Z_LOW: begin
            axis = ASR_AXIS_Z;
         end
         default: begin
            axis = ASR_AXIS_X;
         end
      endcase
      return axis;
   endfunction

   // True once every high byte of the current sample set has been read.
   function automatic logic set_done(input logic [2:0] pending);
      return pending == 3'b000;
   endfunction

   // Packs the combined and per-axis flags into the live status byte.
   function automatic logic [7:0] pack_status(
      input logic any_ow,
      input logic [2:0] axis_ow,
      input logic any_dr,
      input logic [2:0] axis_dr
   );
      logic [7:0] b;
      b = `ASR_STATUS_RESET;
      b[`ASR_BIT_ANY_OW] = any_ow;
      b[`ASR_OW_BASE+2:`ASR_OW_BASE] = axis_ow;
      b[`ASR_BIT_ANY_DR] = any_dr;
      b[`ASR_DR_BASE+2:`ASR_DR_BASE] = axis_dr;
      return b;
   endfunction

   assign fifo_on = (fifo_mode != `ASR_FIFO_OFF);

   //////////////////////////////////////////////////////////////////////
   // Per-axis slots.
   // high read decode
   // Flags are cleared by high reads only while the FIFO is off; with the
   // FIFO on, the same addresses belong to the FIFO path.
   always_comb begin
      read_high = 3'b000;
      if (read_strobe && !fifo_on && is_high_addr(read_addr)) begin
         read_high[axis_of(read_addr)] = 1'b1;
      end
   end

   // One slot per axis; each keeps its own sample, flags and low-byte copy.
   asr_axis_slot #(
      .SAMPLE_W(SAMPLE_W)
   ) u_slot_x (
      .clk(clk),
      .reset_n(reset_n),
      .new_sample(new_sample[ASR_AXIS_X]),
      .sample_in(x_sample_in),
      .read_high(read_high[ASR_AXIS_X]),
      .high_byte(high_byte[ASR_AXIS_X]),
      .low_hold(low_hold[ASR_AXIS_X]),
      .ready(ready[ASR_AXIS_X]),
      .overwrite(overwrite[ASR_AXIS_X])
   );

   asr_axis_slot #(
      .SAMPLE_W(SAMPLE_W)
   ) u_slot_y (
      .clk(clk),
      .reset_n(reset_n),
      .new_sample(new_sample[ASR_AXIS_Y]),
      .sample_in(y_sample_in),
      .read_high(read_high[ASR_AXIS_Y]),
      .high_byte(high_byte[ASR_AXIS_Y]),
      .low_hold(low_hold[ASR_AXIS_Y]),
      .ready(ready[ASR_AXIS_Y]),
      .overwrite(overwrite[ASR_AXIS_Y])
   );

   asr_axis_slot #(
      .SAMPLE_W(SAMPLE_W)
   ) u_slot_z (
      .clk(clk),
      .reset_n(reset_n),
      .new_sample(new_sample[ASR_AXIS_Z]),
      .sample_in(z_sample_in),
      .read_high(read_high[ASR_AXIS_Z]),
      .high_byte(high_byte[ASR_AXIS_Z]),
      .low_hold(low_hold[ASR_AXIS_Z]),
      .ready(ready[ASR_AXIS_Z]),
      .overwrite(overwrite[ASR_AXIS_Z])
   );

   //////////////////////////////////////////////////////////////////////
   // Status byte.
   always_comb begin
      status_byte = pack_status(state.any_overwrite, overwrite, state.any_ready, ready);
   end

   //////////////////////////////////////////////////////////////////////
   // Combined flags, read mux and low-byte window.
   always_comb begin
      next_state = state;
      if (read_strobe) begin
         next_state.low_open = 3'b000;
         case (read_addr)
            `ASR_ADDR_STATUS: begin
               next_state.read_data = fifo_on ? fifo_status : status_byte;
            end
            `ASR_ADDR_X_HIGH: begin
               next_state.read_data = fifo_on ? fifo_data : high_byte[ASR_AXIS_X];
               next_state.low_open[ASR_AXIS_X] = !fifo_on;
            end
            `ASR_ADDR_Y_HIGH: begin
               next_state.read_data = fifo_on ? `ASR_ZERO_BYTE : high_byte[ASR_AXIS_Y];
               next_state.low_open[ASR_AXIS_Y] = !fifo_on;
            end
            `ASR_ADDR_Z_HIGH: begin
               next_state.read_data = fifo_on ? `ASR_ZERO_BYTE : high_byte[ASR_AXIS_Z];
               next_state.low_open[ASR_AXIS_Z] = !fifo_on;
            end
            `ASR_ADDR_X_LOW: begin
               next_state.read_data = `ASR_ZERO_BYTE;
               if (!fifo_on && state.low_open[ASR_AXIS_X]) begin
                  next_state.read_data = low_hold[ASR_AXIS_X];
               end
            end
            `ASR_ADDR_Y_LOW: begin
               next_state.read_data = `ASR_ZERO_BYTE;
               if (!fifo_on && state.low_open[ASR_AXIS_Y]) begin
                  next_state.read_data = low_hold[ASR_AXIS_Y];
               end
            end
            `ASR_ADDR_Z_LOW: begin
               next_state.read_data = `ASR_ZERO_BYTE;
               if (!fifo_on && state.low_open[ASR_AXIS_Z]) begin
                  next_state.read_data = low_hold[ASR_AXIS_Z];
               end
            end
            default: begin
               // Reserved addresses read as zero.
               next_state.read_data = `ASR_ZERO_BYTE;
            end
         endcase
      end
      // Combined flags track one sample set: any new sample starts a set
      // that is complete once all three high bytes have been read.
      // combined overwrite clear
      next_state.highs_pending = state.highs_pending & ~read_high;
      if (set_done(next_state.highs_pending)) begin
         next_state.any_overwrite = 1'b0;
         next_state.any_ready = 1'b0;
      end
      if (|new_sample) begin
         // unretrieved set overwritten
         // A read of the last unread high in this same cycle completes the old
         // set, so only highs still unread after this cycle count as lost.
         if (!set_done(next_state.highs_pending)) begin
            next_state.any_overwrite = 1'b1;
         end
         next_state.any_ready = 1'b1;
         next_state.highs_pending = 3'b111;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign read_data = state.read_data;
   // A FIFO head read pops only through address 0x01; the other data
   // addresses read zero and leave the FIFO alone.
   assign fifo_pop = read_strobe && fifo_on && read_addr == `ASR_ADDR_X_HIGH;
   // The next address is combinational so the front end can step within
   // the strobe cycle; from the status byte both modes go on to 0x01.
   // auto-increment one to six
   assign next_addr = step_addr(read_addr, fast_read);
endmodule
`default_nettype wire

// ### design/asr_params.svh
/*
 * Constants for the accelerometer sample readout register bank.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

`define ASR_ADDR_STATUS 8'h00
`define ASR_ADDR_X_HIGH 8'h01
`define ASR_ADDR_X_LOW 8'h02
`define ASR_ADDR_Y_HIGH 8'h03
`define ASR_ADDR_Y_LOW 8'h04
`define ASR_ADDR_Z_HIGH 8'h05
`define ASR_ADDR_Z_LOW 8'h06
`define ASR_ADDR_LAST 8'h06
`define ASR_BIT_ANY_OW 7
`define ASR_BIT_ANY_DR 3
`define ASR_OW_BASE 4
`define ASR_DR_BASE 0
`define ASR_SAMPLE_W 12
`define ASR_LOW_PAD 4'h0
`define ASR_ZERO_BYTE 8'h00
`define ASR_FIFO_OFF 2'h0
`define ASR_STATUS_RESET 8'h00

`endif

// ### design/asr_pkg.sv
/*
 * Types shared by the sample readout register bank.
 * Assumes nothing of its surroundings.
 */
package asr_pkg;
   typedef enum logic [1:0] {
      ASR_AXIS_X,
      ASR_AXIS_Y,
      ASR_AXIS_Z
   } asr_axis_e;
endpackage

// ### design/asr_axis_slot.sv
/*
 * One axis: holds the sample, its ready and overwrite flags, and the
 * low byte captured when the high byte is read.
 * Assumes the parent decodes high-byte reads and new-sample strobes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "asr_params.svh"
module asr_axis_slot
   import asr_pkg::*;
#(
   parameter int SAMPLE_W = `ASR_SAMPLE_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic new_sample,
   input wire logic [SAMPLE_W-1:0] sample_in,
   input wire logic read_high,
   output logic [7:0] high_byte,
   output logic [7:0] low_hold,
   output logic ready,
   output logic overwrite
);
   // The low byte is the bottom nibble padded with zeros, so the split
   // only works for a 12-bit sample.
   if (SAMPLE_W != `ASR_SAMPLE_W) begin : g_width_check
      $error("asr_axis_slot supports 12-bit samples only");
   end

   typedef struct packed {
      logic [SAMPLE_W-1:0] sample;
      logic [7:0] low_hold;
      logic ready;
      logic overwrite;
   } asr_slot_s;

   asr_slot_s state;
   asr_slot_s next_state;

   always_comb begin
      next_state = state;
      if (read_high) begin
         next_state.low_hold = {state.sample[3:0], `ASR_LOW_PAD};
      end
      if (read_high) begin
         next_state.ready = 1'b0;
         next_state.overwrite = 1'b0;
      end
      if (new_sample) begin
         next_state.sample = sample_in;
         next_state.ready = 1'b1;
         if (state.ready && !read_high) begin
            next_state.overwrite = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign high_byte = state.sample[SAMPLE_W-1:4];
   assign low_hold = state.low_hold;
   assign ready = state.ready;
   assign overwrite = state.overwrite;
endmodule
`default_nettype wire

// ### sim/asr_readout_asserts.sv
/* Port assertions for the sample readout bank.
   Assumes a bind from the bench top. */
`timescale 1ns/10ps
`default_nettype none
module asr_readout_asserts (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] fifo_mode,
   input wire logic fast_read,
   input wire logic [7:0] fifo_status,
   input wire logic [7:0] fifo_data,
   input wire logic fifo_pop,
   input wire logic [2:0] new_sample,
   input wire logic read_strobe,
   input wire logic [7:0] read_addr,
   input wire logic [7:0] read_data,
   input wire logic [7:0] next_addr
);
   logic [7:0] last_addr;
   logic x_pend;
   wire logic fon = (fifo_mode != 2'h0);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Tracks the last strobed address and the expected X ready flag.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         last_addr <= 8'hff;
         x_pend <= 1'b0;
      end else begin
         if (read_strobe) last_addr <= read_addr;
         x_pend <= new_sample[0] | (x_pend & !(read_strobe && !fon && read_addr == 8'h01));
      end
   end
   pop_match_a: assert property (fifo_pop == (read_strobe && fon && read_addr == 8'h01))
      else $error("pop wrong");
   fifo_status_a: assert property (
      read_strobe && fon && read_addr == 8'h00 |=> read_data == $past(fifo_status))
      else $error("fifo status wrong");
   fifo_data_a: assert property (
      read_strobe && fon && read_addr == 8'h01 |=> read_data == $past(fifo_data))
      else $error("fifo data wrong");
   fifo_zero_a: assert property (
      read_strobe && fon && read_addr inside {[8'h02:8'h06]} |=> read_data == 8'h00)
      else $error("fifo zero wrong");
   step_full_a: assert property (
      read_strobe && !fast_read && read_addr < 8'h06 |-> next_addr == read_addr + 8'h01)
      else $error("step wrong");
   wrap_full_a: assert property (
      read_strobe && !fast_read && read_addr == 8'h06 |-> next_addr == 8'h00)
      else $error("wrap wrong");
   step_fast_a: assert property (
      read_strobe && fast_read && read_addr inside {8'h01, 8'h03} |-> next_addr == read_addr + 8'h02)
      else $error("fast step wrong");
   low_refuse_a: assert property (
      read_strobe && !fon && read_addr == 8'h02 && last_addr != 8'h01 |=> read_data == 8'h00)
      else $error("low not refused");
   x_ready_a: assert property (
      read_strobe && !fon && read_addr == 8'h00 |=> read_data[0] == $past(x_pend))
      else $error("x ready wrong");
endmodule
`default_nettype wire

// ### sim/asr_host_model.sv
/* Host model: issues one register read at a time.
   Assumes the bank answers one cycle after the strobe edge. */
`timescale 1ns/10ps
`default_nettype none
module asr_host_model (
   input wire logic clk,
   output logic read_strobe,
   output logic [7:0] read_addr,
   input wire logic [7:0] read_data,
   input wire logic [7:0] next_addr,
   input wire logic fifo_pop
);
   initial begin
      read_strobe = 1'b0;
      read_addr = 8'h00;
   end
   task automatic rd(input logic [7:0] a, output logic [7:0] d, n, output logic p);
      @(posedge clk);
      read_strobe <= 1'b1;
      read_addr <= a;
      #1;
      n = next_addr;
      p = fifo_pop;
      @(posedge clk);
      read_strobe <= 1'b0;
      read_addr <= ~a;
      #1;
      d = read_data;
   endtask
endmodule
`default_nettype wire

// ### sim/asr_readout_tb_top.sv
/* Bench top: readout bank, host model and tests.
   Assumes design, checker and model files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module asr_readout_tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] fifo_mode = 2'h0;
   logic fast_read = 1'b0;
   logic [7:0] fifo_status = 8'h00;
   logic [7:0] fifo_data = 8'h00;
   logic [2:0] new_sample = 3'h0;
   logic [11:0] smp [3] = '{12'h000, 12'h000, 12'h000};
   logic fifo_pop, read_strobe, p;
   logic [7:0] read_addr, read_data, next_addr, d, n, a, e;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   always #4 clk = ~clk;
   asr_readout i_asr_readout (.clk(clk), .reset_n(reset_n), .fifo_mode(fifo_mode),
      .fast_read(fast_read), .fifo_status(fifo_status), .fifo_data(fifo_data),
      .fifo_pop(fifo_pop), .new_sample(new_sample), .x_sample_in(smp[0]),
      .y_sample_in(smp[1]), .z_sample_in(smp[2]), .read_strobe(read_strobe),
      .read_addr(read_addr), .read_data(read_data), .next_addr(next_addr));
   asr_host_model i_asr_host_model (.clk(clk), .read_strobe(read_strobe),
      .read_addr(read_addr), .read_data(read_data), .next_addr(next_addr), .fifo_pop(fifo_pop));
   task automatic stop_test;
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] ad);
      i_asr_host_model.rd(ad, d, n, p);
   endtask
   task automatic push(input logic [2:0] m, input logic [11:0] x, y, z);
      @(posedge clk);
      smp <= '{x, y, z};
      new_sample <= m;
      @(posedge clk);
      new_sample <= 3'h0;
   endtask
   function automatic logic [7:0] wexp(input int i);
      logic [11:0] s;
      s = smp[(i - 1) / 2];
      if (i == 0) return 8'hff;
      return i[0] ? s[11:4] : {s[3:0], 4'h0};
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h00);
      chk("status", 8'h00, d);
      push(3'h7, 12'hf9c, 12'h7ff, 12'h800);
      rd(8'h00);
      chk("status", 8'h0f, d);
      push(3'h7, 12'ha5c, 12'h3c1, 12'h801);
      a = 8'h00;
      for (int i = 0; i < 7; i++) begin
         rd(a);
         chk("walk", wexp(i), d);
         chk("next", i == 6 ? 8'h00 : a + 8'h01, n);
         a = n;
      end
      rd(8'h00);
      chk("status", 8'h00, d);
      rd(8'h01);
      chk("pop", 8'h00, {7'h0, p});
      e = {smp[0][3:0], 4'h0};
      push(3'h1, 12'h0f1, smp[1], smp[2]);
      rd(8'h02);
      chk("held low", e, d);
      rd(8'h00);
      chk("status", 8'h09, d);
      rd(8'h02);
      chk("lone low", 8'h00, d);
      @(posedge clk);
      fast_read <= 1'b1;
      a = 8'h00;
      for (int i = 0; i < 4; i++) begin
         rd(a);
         chk("fast", i == 0 ? 8'h09 : smp[i - 1][11:4], d);
         chk("fast next", i == 3 ? 8'h00 : 8'(2 * i + 1), n);
         a = n;
      end
      @(posedge clk);
      fast_read <= 1'b0;
      fifo_data <= 8'h5a;
      for (int m = 1; m < 4; m++) begin
         @(posedge clk);
         fifo_mode <= 2'(m);
         fifo_status <= 8'(8'h40 + m);
         rd(8'h00);
         chk("fifo status", 8'(8'h40 + m), d);
         rd(8'h01);
         chk("fifo data", 8'h5a, d);
         chk("pop", 8'h01, {7'h0, p});
      end
      for (int k = 2; k < 7; k++) begin
         rd(8'(k));
         chk("fifo zero", 8'h00, d);
      end
      @(posedge clk);
      reset_n <= 1'b0;
      fifo_mode <= 2'h0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h00);
      chk("reset status", 8'h00, d);
      rd(8'h01);
      chk("reset x high", 8'h00, d);
      push(3'h2, smp[0], 12'h123, smp[2]);
      push(3'h2, smp[0], 12'h456, smp[2]);
      rd(8'h00);
      chk("y overwrite", 8'haa, d);
      rd(8'h03);
      chk("y high", 8'h45, d);
      rd(8'h04);
      chk("y low", 8'h60, d);
      rd(8'h00);
      chk("set open", 8'h88, d);
      stop_test();
   end
endmodule
bind asr_readout asr_readout_asserts i_asr_readout_asserts (.clk(clk), .reset_n(reset_n),
   .fifo_mode(fifo_mode), .fast_read(fast_read), .fifo_status(fifo_status),
   .fifo_data(fifo_data), .fifo_pop(fifo_pop), .new_sample(new_sample),
   .read_strobe(read_strobe), .read_addr(read_addr), .read_data(read_data),
   .next_addr(next_addr));
`default_nettype wire
